// ===== hw/pmrc_pkg.sv
// package: register map, field layout and timing for the power mode / regulator config block
//
// Function
// - when the deep-sleep slow-oscillator bit is one, the slow oscillator keeps running in deep sleep.
// - when that bit is zero, the slow oscillator stops on entering deep sleep (recommended).
// - at initialization the sleep-enable status loads from power config bit 8, default one.
// - after initialization sleep-enable is set or cleared by sleep-enable and sleep-disable commands.
// - with overheat shutoff bit 7 set, a severe die over-temperature forces shutdown; clear disables it.
// - bit 6 selects conversion time, zero 3 ms and one 1.5 ms.
// - without balancing, a two-bit field paces the scan loop at full, half, quarter or eighth speed.
// - with balancing, a separate two-bit field paces the scan loop the same way.
// - balancing of a cell is suspended while that cell's voltage is measured.
// - in sleep the wake coulomb counter runs at 48, 24, 12 or 6 ms per code, default code 2.
// - second supply level from bits 7 to 5: 0-3 1.8 V, 4 2.5 V, 5 3 V, 6 3.3 V, 7 5 V.
// - first supply level from bits 3 to 1 with the same encoding.
// - second supply enable comes from bit 4, reapplied at each init after reset or deep sleep.
// - first supply enable comes from bit 0, reapplied at each init after reset or deep sleep.
package pmrc_pkg;
   localparam logic [11:0] PMRC_OFS_PWR_CFG   = 12'h000;
   localparam logic [11:0] PMRC_OFS_REG_CFG   = 12'h004;
   localparam logic [11:0] PMRC_OFS_CMD       = 12'h008;
   localparam logic [11:0] PMRC_OFS_STATUS    = 12'h00C;
   localparam logic [11:0] PMRC_OFS_MEAS      = 12'h010;

   localparam logic [15:0] PMRC_PWR_RST       = 16'h0182;
   localparam logic [7:0]  PMRC_REG_RST       = 8'h00;

   localparam int PMRC_B_LFO      = 9;
   localparam int PMRC_B_SLEEP    = 8;
   localparam int PMRC_B_DIE_OVERHEAT_SHUTOFF     = 7;
   localparam int PMRC_B_FAST     = 6;
   localparam int PMRC_B_CBLOOP   = 4;
   localparam int PMRC_B_LOOP     = 2;
   localparam int PMRC_B_WAKE     = 0;
   localparam int PMRC_B_R2LVL    = 5;
   localparam int PMRC_B_R2ON     = 4;
   localparam int PMRC_B_R1LVL    = 1;
   localparam int PMRC_B_R1ON     = 0;

   // command register bits (write one to act)
   localparam int PMRC_C_SLP_EN   = 0;
   localparam int PMRC_C_SLP_DIS  = 1;
   localparam int PMRC_C_INIT     = 2;

   localparam int PMRC_CLK_MHZ    = 125;
   localparam int PMRC_CONV_SLOW_US = 3000;
   localparam int PMRC_CONV_FAST_US = 1500;
   localparam int PMRC_WAKE_BASE_MS = 6;
   localparam int PMRC_CONV_SLOW_CYC = PMRC_CONV_SLOW_US * PMRC_CLK_MHZ;
   localparam int PMRC_CONV_FAST_CYC = PMRC_CONV_FAST_US * PMRC_CLK_MHZ;
   localparam int PMRC_WAKE_BASE_CYC = PMRC_WAKE_BASE_MS * 1000 * PMRC_CLK_MHZ;

   typedef enum logic [2:0] {
      PMRC_LVL_1V8, PMRC_LVL_2V5, PMRC_LVL_3V0, PMRC_LVL_3V3, PMRC_LVL_5V0
   } pmrc_lvl_t;
endpackage

// ===== hw/pmrc_ticker.sv
// ticker: emits a one-cycle pulse every period cycles
`timescale 1ns/100ps
`default_nettype none
module pmrc_ticker (
   input  wire logic        clk_sys_i,   // system clock
   input  wire logic        rstn_i,      // async reset, low
   input  wire logic        run_i,       // count while high
   input  wire logic [31:0] period_i,    // cycles per tick
   output logic             tick_o       // one-cycle pulse
);
   logic [31:0] cnt_reg;
   wire         last_w = (cnt_reg + 32'h1 >= period_i);

   always_ff @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
         cnt_reg <= 32'h0;
         tick_o  <= 1'b0;
      end else begin
         tick_o  <= run_i && last_w;
         cnt_reg <= (!run_i || last_w) ? 32'h0 : cnt_reg + 32'h1;
      end
   end
endmodule
`default_nettype wire

// ===== hw/pmrc_top.sv
// top: APB register bank and config-driven power mode, scan pacing and supply control
`timescale 1ns/100ps
`default_nettype none
module pmrc_top
   import pmrc_pkg::*;
#(
   parameter int CONV_SLOW_CYC = PMRC_CONV_SLOW_CYC,
   parameter int CONV_FAST_CYC = PMRC_CONV_FAST_CYC,
   parameter int WAKE_BASE_CYC = PMRC_WAKE_BASE_CYC
) (
   input  wire logic        clk_sys_i,          // 125 MHz clock
   input  wire logic        rstn_i,             // async reset, low
   input  wire logic        psel,               // apb select
   input  wire logic        penable,            // apb enable
   input  wire logic        pwrite,             // apb direction
   input  wire logic [11:0] paddr,              // apb byte address
   input  wire logic [31:0] pwdata,             // apb write data
   output logic [31:0]      prdata,             // apb read data
   output logic             pready,             // apb ready
   output logic             pslverr,            // apb error
   input  wire logic        deep_sleep_req_i,   // async: request deep sleep
   input  wire logic        in_sleep_i,         // async: device in sleep mode
   input  wire logic        die_overheat_i,     // async: severe die over-temperature
   input  wire logic        balancing_i,        // async: cell balancing active
   output logic             slow_osc_run_o,     // slow oscillator enable
   output logic             deep_sleep_o,       // in deepest low power state
   output logic             shutdown_o,         // shutdown requested
   output logic             sleep_allowed_o,    // sleep enable status
   output logic             first_supply_output_o,  // first supply enable
   output logic             second_supply_output_o, // second supply enable
   output logic [2:0]       first_supply_level_o,   // pmrc_lvl_t
   output logic [2:0]       second_supply_level_o,  // pmrc_lvl_t
   output logic             conv_done_o,        // conversion done pulse
   output logic             volt_scan_o,        // conversion is a voltage scan
   output logic             balance_pause_o,    // pause balancing of measured cell
   output logic             wake_sample_o       // wake counter sample pulse
);
   ////////////////////////////////////////////////////////////////////////////
   function automatic logic [2:0] lvl_decode(input logic [2:0] code);
      case (code)
         3'h4:    lvl_decode = 3'(PMRC_LVL_2V5);
         3'h5:    lvl_decode = 3'(PMRC_LVL_3V0);
         3'h6:    lvl_decode = 3'(PMRC_LVL_3V3);
         3'h7:    lvl_decode = 3'(PMRC_LVL_5V0);
         default: lvl_decode = 3'(PMRC_LVL_1V8);
      endcase
   endfunction

   // slowdown code 0..3 gives 2**code loops of which one is a voltage scan
   function automatic logic [3:0] loop_len(input logic [1:0] code);
      loop_len = 4'h1 << code;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // input synchronisers
   logic [3:0] sync1_reg;
   logic [3:0] sync2_reg;
   always_ff @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
         sync1_reg <= 4'h0;
         sync2_reg <= 4'h0;
      end else begin
         sync1_reg <= {deep_sleep_req_i, in_sleep_i, die_overheat_i, balancing_i};
         sync2_reg <= sync1_reg;
      end
   end
   wire dsr_w = sync2_reg[3];
   wire slp_w = sync2_reg[2];
   wire hot_w = sync2_reg[1];
   wire bal_w = sync2_reg[0];

   ////////////////////////////////////////////////////////////////////////////
   // apb decode
   wire acc_w    = psel && penable;
   wire wr_w     = acc_w && pwrite;
   wire sel_pwr  = (paddr == PMRC_OFS_PWR_CFG);
   wire sel_reg  = (paddr == PMRC_OFS_REG_CFG);
   wire sel_cmd  = (paddr == PMRC_OFS_CMD);
   wire sel_sts  = (paddr == PMRC_OFS_STATUS);
   wire sel_meas = (paddr == PMRC_OFS_MEAS);
   wire mapped_w = sel_pwr || sel_reg || sel_cmd || sel_sts || sel_meas;
   wire cmd_wr_w = wr_w && sel_cmd;
   wire c_slp_en = cmd_wr_w && pwdata[PMRC_C_SLP_EN];
   wire c_slp_di = cmd_wr_w && pwdata[PMRC_C_SLP_DIS];
   wire c_init   = cmd_wr_w && pwdata[PMRC_C_INIT];

   assign pready  = 1'b1;
   assign pslverr = acc_w && !mapped_w;

   logic [15:0] pwr_cfg_reg;
   logic [7:0]  reg_cfg_reg;
   always_ff @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
         pwr_cfg_reg <= PMRC_PWR_RST;
         reg_cfg_reg <= PMRC_REG_RST;
      end else begin
         if (wr_w && sel_pwr) pwr_cfg_reg <= pwdata[15:0];
         if (wr_w && sel_reg) reg_cfg_reg <= pwdata[7:0];
      end
   end

   wire       f_lfo   = pwr_cfg_reg[PMRC_B_LFO];
   wire       f_sleep = pwr_cfg_reg[PMRC_B_SLEEP];
   wire       f_die_overheat_shutoff  = pwr_cfg_reg[PMRC_B_DIE_OVERHEAT_SHUTOFF];
   wire       f_fast  = pwr_cfg_reg[PMRC_B_FAST];
   wire [1:0] f_cbl   = pwr_cfg_reg[PMRC_B_CBLOOP +: 2];
   wire [1:0] f_loop  = pwr_cfg_reg[PMRC_B_LOOP +: 2];
   wire [1:0] f_wake  = pwr_cfg_reg[PMRC_B_WAKE +: 2];

   ////////////////////////////////////////////////////////////////////////////
   // power state: init pulse after reset release and after leaving deep sleep
   logic init_reg;
   logic boot_reg;
   logic deep_reg;
   logic shut_reg;
   logic slp_en_reg;
   wire  leave_deep_w = deep_reg && !dsr_w;

   always_ff @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
         boot_reg <= 1'b1;
         init_reg <= 1'b0;
         deep_reg <= 1'b0;
         shut_reg <= 1'b0;
      end else begin
         boot_reg <= 1'b0;
         init_reg <= boot_reg || leave_deep_w || c_init;
         deep_reg <= dsr_w && !shut_reg;
         if (f_die_overheat_shutoff && hot_w) shut_reg <= 1'b1;
      end
   end

   always_ff @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
         slp_en_reg <= 1'b0;
      end else if (init_reg) begin
         slp_en_reg <= f_sleep;
      end else if (c_slp_en) begin
         slp_en_reg <= 1'b1;
      end else if (c_slp_di) begin
         slp_en_reg <= 1'b0;
      end
   end

   // supplies: enables reapplied at init, levels follow their fields
   logic s1_on_reg;
   logic s2_on_reg;
   always_ff @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
         s1_on_reg <= 1'b0;
         s2_on_reg <= 1'b0;
         first_supply_level_o  <= 3'(PMRC_LVL_1V8);
         second_supply_level_o <= 3'(PMRC_LVL_1V8);
      end else begin
         if (init_reg) begin
            s1_on_reg <= reg_cfg_reg[PMRC_B_R1ON];
            s2_on_reg <= reg_cfg_reg[PMRC_B_R2ON];
         end
         first_supply_level_o  <= lvl_decode(reg_cfg_reg[PMRC_B_R1LVL +: 3]);
         second_supply_level_o <= lvl_decode(reg_cfg_reg[PMRC_B_R2LVL +: 3]);
      end
   end

   assign first_supply_output_o  = s1_on_reg && !shut_reg;
   assign second_supply_output_o = s2_on_reg && !shut_reg;
   assign slow_osc_run_o  = !shut_reg && (!deep_reg || f_lfo);
   assign deep_sleep_o    = deep_reg;
   assign shutdown_o      = shut_reg;
   assign sleep_allowed_o = slp_en_reg;

   ////////////////////////////////////////////////////////////////////////////
   // conversion pacing
   wire        active_w = !deep_reg && !shut_reg;
   wire [31:0] conv_per = f_fast ? 32'(CONV_FAST_CYC) : 32'(CONV_SLOW_CYC);
   wire        conv_tick;
   pmrc_ticker u_conv (
      .clk_sys_i (clk_sys_i),
      .rstn_i    (rstn_i),
      .run_i     (active_w && !slp_w),
      .period_i  (conv_per),
      .tick_o    (conv_tick)
   );

   // loop position; position 0 is the voltage/temperature scan, rest current only
   logic [3:0] loop_pos_reg;
   wire  [3:0] loop_n   = bal_w ? loop_len(f_cbl) : loop_len(f_loop);
   wire        loop_end = (loop_pos_reg + 4'h1 >= loop_n);
   always_ff @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
         loop_pos_reg <= 4'h0;
      end else if (conv_tick) begin
         loop_pos_reg <= loop_end ? 4'h0 : loop_pos_reg + 4'h1;
      end
   end
   assign conv_done_o     = conv_tick;
   assign volt_scan_o     = active_w && !slp_w && (loop_pos_reg == 4'h0);
   assign balance_pause_o = bal_w && volt_scan_o;

   // wake counter in sleep
   wire [31:0] wake_per = 32'(WAKE_BASE_CYC) << (2'h3 - f_wake);
   pmrc_ticker u_wake (
      .clk_sys_i (clk_sys_i),
      .rstn_i    (rstn_i),
      .run_i     (active_w && slp_w),
      .period_i  (wake_per),
      .tick_o    (wake_sample_o)
   );

   ////////////////////////////////////////////////////////////////////////////
   // read mux
   wire [31:0] sts_w = {24'h0, wake_sample_o, balance_pause_o, s2_on_reg, s1_on_reg,
                        slow_osc_run_o, shut_reg, deep_reg, slp_en_reg};
   wire [31:0] rd_w  = sel_pwr  ? {16'h0, pwr_cfg_reg} :
                       sel_reg  ? {24'h0, reg_cfg_reg} :
                       sel_sts  ? sts_w :
                       sel_meas ? {28'h0, loop_pos_reg} : 32'h0;
   always_ff @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) prdata <= 32'h0;
      else if (psel && !penable && !pwrite) prdata <= rd_w;
   end

   ////////////////////////////////////////////////////////////////////////////
   property p_osc_deep;
      @(posedge clk_sys_i) disable iff (!rstn_i)
      (deep_reg && !shut_reg) |-> (slow_osc_run_o == f_lfo);
   endproperty
   a_osc_deep: assert property (p_osc_deep) else $error("osc state wrong in deep sleep");

   property p_osc_stop;
      @(posedge clk_sys_i) disable iff (!rstn_i)
      (deep_reg && !f_lfo) |-> !slow_osc_run_o;
   endproperty
   a_osc_stop: assert property (p_osc_stop) else $error("osc not stopped");

   property p_init_sleep;
      @(posedge clk_sys_i) disable iff (!rstn_i)
      init_reg |=> (slp_en_reg == $past(f_sleep));
   endproperty
   a_init_sleep: assert property (p_init_sleep) else $error("sleep enable not loaded");

   property p_slp_cmd;
      @(posedge clk_sys_i) disable iff (!rstn_i)
      (c_slp_en && !init_reg) |=> slp_en_reg;
   endproperty
   a_slp_cmd: assert property (p_slp_cmd) else $error("sleep enable cmd lost");

   property p_shut;
      @(posedge clk_sys_i) disable iff (!rstn_i)
      (f_die_overheat_shutoff && hot_w) |=> shutdown_o ##1 !first_supply_output_o;
   endproperty
   a_shut: assert property (p_shut) else $error("no overheat shutdown");

   property p_conv_per;
      @(posedge clk_sys_i) disable iff (!rstn_i)
      (conv_per == (f_fast ? 32'(CONV_FAST_CYC) : 32'(CONV_SLOW_CYC)));
   endproperty
   a_conv_per: assert property (p_conv_per) else $error("conversion period wrong");

   property p_loop;
      @(posedge clk_sys_i) disable iff (!rstn_i)
      (conv_tick && loop_end) |=> (loop_pos_reg == 4'h0);
   endproperty
   a_loop: assert property (p_loop) else $error("scan loop did not wrap");

   property p_bal;
      @(posedge clk_sys_i) disable iff (!rstn_i)
      (bal_w && volt_scan_o) |-> balance_pause_o;
   endproperty
   a_bal: assert property (p_bal) else $error("balancing not paused");

   property p_supply;
      @(posedge clk_sys_i) disable iff (!rstn_i)
      init_reg |=> (s1_on_reg == $past(reg_cfg_reg[PMRC_B_R1ON]))
                && (s2_on_reg == $past(reg_cfg_reg[PMRC_B_R2ON]));
   endproperty
   a_supply: assert property (p_supply) else $error("supply enable not reapplied");

   property p_lvl;
      @(posedge clk_sys_i) disable iff (!rstn_i)
      (reg_cfg_reg[7:5] == 3'h7) |=> (second_supply_level_o == 3'(PMRC_LVL_5V0));
   endproperty
   a_lvl: assert property (p_lvl) else $error("level decode wrong");
endmodule
`default_nettype wire

// ===== test/tb_top.sv
// testbench: apb driven checks of the power mode and supply config block
`timescale 1ns/100ps
`default_nettype none
module tb_top;
   import pmrc_pkg::*;

   logic        clk_sys_i = 1'b0;
   logic        rstn_i = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h00000000;
   logic        deep_sleep_req_i = 1'b0;
   logic        in_sleep_i = 1'b0;
   logic        die_overheat_i = 1'b0;
   logic        balancing_i = 1'b0;
   logic [31:0] prdata;
   logic        pready, pslverr, slow_osc_run_o, deep_sleep_o, shutdown_o, sleep_allowed_o;
   logic        first_supply_output_o, second_supply_output_o, conv_done_o, volt_scan_o;
   logic        balance_pause_o, wake_sample_o;
   logic [2:0]  first_supply_level_o, second_supply_level_o;
   int          miscompares = 0;
   int          samples_checked = 0;

   always #4 clk_sys_i = ~clk_sys_i;

   pmrc_top #(.CONV_SLOW_CYC(20), .CONV_FAST_CYC(10), .WAKE_BASE_CYC(8)) pmrc_top_i (
      .clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .deep_sleep_req_i(deep_sleep_req_i), .in_sleep_i(in_sleep_i),
      .die_overheat_i(die_overheat_i), .balancing_i(balancing_i),
      .slow_osc_run_o(slow_osc_run_o), .deep_sleep_o(deep_sleep_o), .shutdown_o(shutdown_o),
      .sleep_allowed_o(sleep_allowed_o), .first_supply_output_o(first_supply_output_o),
      .second_supply_output_o(second_supply_output_o),
      .first_supply_level_o(first_supply_level_o),
      .second_supply_level_o(second_supply_level_o), .conv_done_o(conv_done_o),
      .volt_scan_o(volt_scan_o), .balance_pause_o(balance_pause_o),
      .wake_sample_o(wake_sample_o));

   ////////////////////////////////////////////////////////////////////////////
   task automatic wrap_up();
      $display("comparisons %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         miscompares++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge clk_sys_i);
   endtask

   // one apb transfer; read data and error taken at the completing edge
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic err);
      int k;
      @(posedge clk_sys_i);
      psel    <= 1'b1;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clk_sys_i);
      penable <= 1'b1;
      for (k = 0; k < 50; k++) begin
         @(posedge clk_sys_i);
         if (pready === 1'b1) break;
      end
      if (k == 50) begin
         miscompares++;
         wrap_up();
      end
      rd  = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic        e;
      apb(1'b1, a, d, r, e);
      chk({31'h0, e}, 32'h0);
      // let the write settle before callers look at outputs
      cyc(1);
   endtask

   // count voltage scans among 16 conversions after one settling conversion
   task automatic scans(input logic bal, output int v);
      int k;
      int p;
      v = 0;
      p = 0;
      cyc(3);
      for (k = 0; k < 1000 && p < 17; k++) begin
         cyc(1);
         if (conv_done_o === 1'b1) begin
            if (p > 0 && volt_scan_o === 1'b1) v++;
            p++;
         end
         if (volt_scan_o === 1'b1) chk({31'h0, balance_pause_o}, {31'h0, bal});
      end
      if (k == 1000) begin
         miscompares++;
         wrap_up();
      end
   endtask

   // cycles between two pulses of the wake sample or conversion done output
   task automatic period(input bit w, output int n);
      int k;
      for (k = 0; k < 400 && (w ? wake_sample_o : conv_done_o) !== 1'b1; k++) cyc(1);
      cyc(1);
      for (n = 1; n < 400 && (w ? wake_sample_o : conv_done_o) !== 1'b1; n++) cyc(1);
      if (k == 400 || n == 400) begin
         miscompares++;
         wrap_up();
      end
   endtask

   ////////////////////////////////////////////////////////////////////////////
   task automatic t_reset();
      logic [31:0] r;
      logic        e;
      apb(1'b0, PMRC_OFS_PWR_CFG, 32'h0, r, e);
      chk(r, 32'h00000182);
      apb(1'b0, PMRC_OFS_REG_CFG, 32'h0, r, e);
      chk(r, 32'h00000000);
      chk({31'h0, sleep_allowed_o}, 32'h1);
      apb(1'b0, 12'h020, 32'h0, r, e);
      chk({r[30:0], e}, 32'h1);
      $display("test reset values done");
   endtask

   task automatic t_sleep_cmd();
      wr(PMRC_OFS_CMD, 32'h2);
      chk({31'h0, sleep_allowed_o}, 32'h0);
      wr(PMRC_OFS_CMD, 32'h1);
      chk({31'h0, sleep_allowed_o}, 32'h1);
      wr(PMRC_OFS_PWR_CFG, 32'h0082);
      wr(PMRC_OFS_CMD, 32'h4);
      cyc(2);
      chk({31'h0, sleep_allowed_o}, 32'h0);
      wr(PMRC_OFS_PWR_CFG, 32'h0182);
      wr(PMRC_OFS_CMD, 32'h4);
      cyc(2);
      chk({31'h0, sleep_allowed_o}, 32'h1);
      $display("test sleep enable done");
   endtask

   task automatic t_levels();
      logic [2:0] exp;
      for (int c = 0; c < 8; c++) begin
         wr(PMRC_OFS_REG_CFG, 32'((c << 5) | (c << 1)));
         cyc(2);
         exp = (c < 4) ? 3'h0 : 3'(c - 3);
         chk({29'h0, second_supply_level_o}, {29'h0, exp});
         chk({29'h0, first_supply_level_o}, {29'h0, exp});
      end
      $display("test supply levels done");
   endtask

   task automatic t_deep(input logic [31:0] cfg, input logic osc);
      wr(PMRC_OFS_PWR_CFG, cfg);
      deep_sleep_req_i <= 1'b1;
      cyc(5);
      chk({31'h0, deep_sleep_o}, 32'h1);
      chk({31'h0, slow_osc_run_o}, {31'h0, osc});
      deep_sleep_req_i <= 1'b0;
      cyc(6);
   endtask

   task automatic t_supply();
      wr(PMRC_OFS_REG_CFG, 32'h11);
      cyc(2);
      chk({30'h0, second_supply_output_o, first_supply_output_o}, 32'h0);
      t_deep(32'h0182, 1'b0);
      chk({30'h0, second_supply_output_o, first_supply_output_o}, 32'h3);
      t_deep(32'h0382, 1'b1);
      wr(PMRC_OFS_REG_CFG, 32'h10);
      wr(PMRC_OFS_CMD, 32'h4);
      cyc(2);
      chk({30'h0, second_supply_output_o, first_supply_output_o}, 32'h2);
      $display("test supply enables and oscillator done");
   endtask

   task automatic t_timing();
      int n;
      wr(PMRC_OFS_PWR_CFG, 32'h0182);
      period(1'b0, n);
      period(1'b0, n);
      chk(32'(n), 32'd20);
      wr(PMRC_OFS_PWR_CFG, 32'h01C2);
      period(1'b0, n);
      period(1'b0, n);
      chk(32'(n), 32'd10);
      in_sleep_i <= 1'b1;
      for (int c = 0; c < 4; c++) begin
         wr(PMRC_OFS_PWR_CFG, 32'(12'h180 | c));
         period(1'b1, n);
         period(1'b1, n);
         chk(32'(n), 32'(8 << (3 - c)));
      end
      in_sleep_i <= 1'b0;
      $display("test conversion and wake timing done");
   endtask

   // balancing and normal pacing fields set differently so the selection shows
   task automatic t_balance();
      int v;
      for (int c = 0; c < 4; c++) begin
         wr(PMRC_OFS_PWR_CFG, 32'(12'h182 | ((3 - c) << 4) | (c << 2)));
         balancing_i <= 1'b1;
         scans(1'b1, v);
         chk(32'(v), 32'(16 >> (3 - c)));
         balancing_i <= 1'b0;
         scans(1'b0, v);
         chk(32'(v), 32'(16 >> c));
      end
      $display("test scan pacing and balancing pause done");
   endtask

   task automatic t_overheat();
      wr(PMRC_OFS_PWR_CFG, 32'h0102);
      die_overheat_i <= 1'b1;
      cyc(5);
      chk({31'h0, shutdown_o}, 32'h0);
      die_overheat_i <= 1'b0;
      wr(PMRC_OFS_PWR_CFG, 32'h0182);
      die_overheat_i <= 1'b1;
      cyc(5);
      chk({31'h0, shutdown_o}, 32'h1);
      $display("test overheat shutoff done");
   endtask

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      cyc(20);
      rstn_i <= 1'b1;
      cyc(4);
      t_reset();
      t_sleep_cmd();
      t_levels();
      t_supply();
      t_timing();
      t_balance();
      t_overheat();
      wrap_up();
   end
endmodule
`default_nettype wire
